/* File: design/arf_defines.svh */
// Register offsets, field positions and reset values of the result formatter.
// Included by the package and the modules; holds definitions only.
`ifndef ARF_DEFINES_SVH
`define ARF_DEFINES_SVH

// Byte offsets on the Wishbone bus, one aligned word each
`define ARF_OFF_CTRL0   8'h00
`define ARF_OFF_CTRL1   8'h04
`define ARF_OFF_TRIG    8'h08
`define ARF_OFF_RES_LO  8'h0C
`define ARF_OFF_RES_HI  8'h10

// Word index of each register (byte offset / 4)
`define ARF_IDX_CTRL0   3'h0
`define ARF_IDX_CTRL1   3'h1
`define ARF_IDX_TRIG    3'h2
`define ARF_IDX_RES_LO  3'h3
`define ARF_IDX_RES_HI  3'h4

// Field positions in converter_control_0
`define ARF_C0_PWR      0
`define ARF_C0_BUSY     1
`define ARF_C0_CHAN_LO  2
`define ARF_C0_CHAN_HI  6
// Field positions in converter_control_1
`define ARF_C1_PREF_LO  0
`define ARF_C1_PREF_HI  1
`define ARF_C1_NREF     2
`define ARF_C1_CLK_LO   4
`define ARF_C1_CLK_HI   6
`define ARF_C1_JUST     7
// Field positions in converter_trigger_control
`define ARF_TR_SEL_LO   4
`define ARF_TR_SEL_HI   7

// Conversion result width
`define ARF_RES_W       10

// Reset value of every control field
`define ARF_CTRL_RST    1'b0
`define ARF_FIELD2_RST  2'h0
`define ARF_FIELD3_RST  3'h0
`define ARF_FIELD4_RST  4'h0
`define ARF_FIELD5_RST  5'h00

`endif

/* File: design/arf_pkg.sv */
// Types shared by the result formatter modules.
// Assumes arf_defines.svh is on the include path.
`include "arf_defines.svh"

package arf_pkg;

	// Whole state of the top module, registered as one word
	typedef struct packed {
		logic [4:0] input_channel_select;  // Analog channel
		logic       conv_busy;             // Conversion status bit
		logic       converter_power_enable;// Converter enable
		logic       result_justify_select; // 1 right, 0 left
		logic [2:0] conv_clk_sel;          // Conversion clock choice
		logic       neg_ref_sel;           // Negative reference choice
		logic [1:0] pos_ref_sel;           // Positive reference choice
		logic [3:0] trig_sel;              // Auto trigger source
		logic [7:0] result_low_byte;       // Low result byte
		logic [7:0] result_high_byte;      // High result byte
		logic       ack;                   // Bus acknowledge
		logic [7:0] rdata;                 // Read data byte
	} arf_state_t;

endpackage : arf_pkg

/* File: design/arf_justify.sv */
// Places a 10-bit conversion result into the two result bytes.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ps
`include "arf_defines.svh"

module arf_justify #(
	parameter int RES_W = `ARF_RES_W  // Result width
) (
	input  wire logic [RES_W-1:0] conversion_result, // Raw result
	input  wire logic             right_justify,     // Format select
	output logic      [7:0]       fmt_high_byte,     // High byte image
	output logic      [7:0]       fmt_low_byte       // Low byte image
);
	import arf_pkg::*;

	// Byte split is hard-wired for exactly ten bits
	if (RES_W != 10) begin : g_chk
		$error("arf_justify supports a 10-bit result only");
	end

	// Format mux
	always_comb begin
		if (right_justify) begin
			fmt_high_byte = {6'h00, conversion_result[9:8]};
			fmt_low_byte  = conversion_result[7:0];
		end else begin
			fmt_high_byte = conversion_result[9:2];
			fmt_low_byte  = {conversion_result[1:0], 6'h00};
		end
	end

endmodule : arf_justify

/* File: design/arf_top.sv */
// Result formatter and control registers of a 10-bit converter, Wishbone slave.
// Assumes a converter engine that pulses conv_done with conv_data valid.
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "arf_defines.svh"

module arf_top #(
	parameter int ADDR_W = 8,          // Wishbone address width
	parameter int RES_W  = `ARF_RES_W  // Conversion result width
) (
	input  wire logic              sys_clk,      // System clock, 100 MHz
	input  wire logic              rst_n,        // Synchronous reset, low
	input  wire logic              wb_cyc_i,     // Bus cycle
	input  wire logic              wb_stb_i,     // Strobe
	input  wire logic              wb_we_i,      // Write enable
	input  wire logic [ADDR_W-1:0] wb_adr_i,     // Byte address
	input  wire logic [3:0]        wb_sel_i,     // Byte lanes
	input  wire logic [31:0]       wb_dat_i,     // Write data
	output logic      [31:0]       wb_dat_o,     // Read data
	output logic                   wb_ack_o,     // Acknowledge
	input  wire logic              conv_done,    // Engine finished, pulse
	input  wire logic [RES_W-1:0]  conv_data,    // Engine result
	output logic                   conv_start,   // Conversion requested
	output logic                   conv_power,   // Engine enable
	output logic      [4:0]        conv_channel, // Channel select
	output logic      [2:0]        conv_clk_sel, // Conversion clock choice
	output logic                   conv_nref,    // Negative reference
	output logic      [1:0]        conv_pref,    // Positive reference
	output logic      [3:0]        conv_trig_sel // Auto trigger source
);
	import arf_pkg::*;

	// Offsets need bits 4:2, and the unmapped decode slices bits above bit 4
	if (ADDR_W < 6) begin : g_chk_addr
		$error("arf_top needs at least 6 address bits");
	end
	if (RES_W != 10) begin : g_chk_res
		$error("arf_top supports a 10-bit result only");
	end

	arf_state_t st_ff;        // Registered state
	arf_state_t nxt_st;       // Next state
	logic [7:0] fmt_hi;       // Formatted high byte
	logic [7:0] fmt_lo;       // Formatted low byte
	logic       bus_take;     // Request taken this cycle
	logic       wr_take;      // Write taken on lane 0
	logic [2:0] idx;          // Register word index
	logic       in_map;       // Address decodes to a register
	logic       done_take;    // Completion accepted
	logic       sw_start;     // Software sets the status bit
	logic [7:0] wbyte;        // Written byte

	// Formatting of the engine result
	arf_justify #(
		.RES_W (RES_W)
	) u_justify (
		.conversion_result (conv_data),
		.right_justify     (st_ff.result_justify_select),
		.fmt_high_byte     (fmt_hi),
		.fmt_low_byte      (fmt_lo)
	);

	// Bus decode; one request per ack so a held strobe is not taken twice
	always_comb begin
		bus_take  = wb_cyc_i & wb_stb_i & ~st_ff.ack;
		wr_take   = bus_take & wb_we_i & wb_sel_i[0];
		idx       = wb_adr_i[4:2];
		in_map    = (wb_adr_i[ADDR_W-1:5] == '0) && (wb_adr_i[1:0] == 2'h0) && (idx <= `ARF_IDX_RES_HI);
		wbyte     = wb_dat_i[7:0];
		sw_start  = wr_take & in_map & (idx == `ARF_IDX_CTRL0) & wbyte[`ARF_C0_BUSY];
		// Only a running conversion may complete; stray pulses are dropped
		done_take = conv_done & st_ff.conv_busy;
	end

	// Next-state logic
	always_comb begin
		nxt_st     = st_ff;
		nxt_st.ack = bus_take;
		// Read data registered with ack; unmapped reads return zero
		nxt_st.rdata = 8'h00;
		if (bus_take && !wb_we_i && in_map) begin
			unique case (idx)
				`ARF_IDX_CTRL0:  nxt_st.rdata = {1'b0, st_ff.input_channel_select,
				                                 st_ff.conv_busy, st_ff.converter_power_enable};
				`ARF_IDX_CTRL1:  nxt_st.rdata = {st_ff.result_justify_select, st_ff.conv_clk_sel,
				                                 1'b0, st_ff.neg_ref_sel, st_ff.pos_ref_sel};
				`ARF_IDX_TRIG:   nxt_st.rdata = {st_ff.trig_sel, 4'h0};
				`ARF_IDX_RES_LO: nxt_st.rdata = st_ff.result_low_byte;
				`ARF_IDX_RES_HI: nxt_st.rdata = st_ff.result_high_byte;
				default:         nxt_st.rdata = 8'h00;
			endcase
		end
		// Register writes; unmapped writes are acked and ignored
		if (wr_take && in_map) begin
			unique case (idx)
				`ARF_IDX_CTRL0: begin
					nxt_st.input_channel_select   = wbyte[`ARF_C0_CHAN_HI:`ARF_C0_CHAN_LO];
					nxt_st.conv_busy              = wbyte[`ARF_C0_BUSY];
					nxt_st.converter_power_enable = wbyte[`ARF_C0_PWR];
				end
				`ARF_IDX_CTRL1: begin
					nxt_st.result_justify_select = wbyte[`ARF_C1_JUST];
					nxt_st.conv_clk_sel          = wbyte[`ARF_C1_CLK_HI:`ARF_C1_CLK_LO];
					nxt_st.neg_ref_sel           = wbyte[`ARF_C1_NREF];
					nxt_st.pos_ref_sel           = wbyte[`ARF_C1_PREF_HI:`ARF_C1_PREF_LO];
				end
				`ARF_IDX_TRIG: begin
					nxt_st.trig_sel = wbyte[`ARF_TR_SEL_HI:`ARF_TR_SEL_LO];
				end
				`ARF_IDX_RES_LO: begin
					nxt_st.result_low_byte = wbyte;
				end
				`ARF_IDX_RES_HI: begin
					nxt_st.result_high_byte = wbyte;
				end
				default: begin
					nxt_st.rdata = 8'h00;
				end
			endcase
		end
		// Completion: both bytes and the status bit move on one edge
		if (done_take) begin
			nxt_st.result_high_byte = fmt_hi;
			nxt_st.result_low_byte  = fmt_lo;
			// A start written in the same cycle begins the next conversion
			nxt_st.conv_busy = sw_start;
		end
		// Reset clears control, ack and read data; result bytes keep their contents
		if (!rst_n) begin
			nxt_st.input_channel_select   = `ARF_FIELD5_RST;
			nxt_st.conv_busy              = `ARF_CTRL_RST;
			nxt_st.converter_power_enable = `ARF_CTRL_RST;
			nxt_st.result_justify_select  = `ARF_CTRL_RST;
			nxt_st.conv_clk_sel           = `ARF_FIELD3_RST;
			nxt_st.neg_ref_sel            = `ARF_CTRL_RST;
			nxt_st.pos_ref_sel            = `ARF_FIELD2_RST;
			nxt_st.trig_sel               = `ARF_FIELD4_RST;
			nxt_st.ack                    = `ARF_CTRL_RST;
			nxt_st.rdata                  = 8'h00;
		end
	end

	// State register; the result bytes are never reset
	always_ff @(posedge sys_clk) begin
		st_ff <= nxt_st;
	end

	// Outputs straight from the state register
	always_comb begin
		wb_ack_o      = st_ff.ack;
		wb_dat_o      = {24'h000000, st_ff.rdata};
		// Engine acts on this level; acquisition timing is software's job
		conv_start    = st_ff.conv_busy;
		conv_power    = st_ff.converter_power_enable;
		conv_channel  = st_ff.input_channel_select;
		conv_clk_sel  = st_ff.conv_clk_sel;
		conv_nref     = st_ff.neg_ref_sel;
		conv_pref     = st_ff.pos_ref_sel;
		conv_trig_sel = st_ff.trig_sel;
	end

	// Checks on the stored result, status and bus ack
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic done_left;   // Left-format completion
	logic done_right;  // Right-format completion
	logic res_write;   // Software writes a result byte
	always_comb begin
		done_left  = done_take & ~st_ff.result_justify_select;
		done_right = done_take & st_ff.result_justify_select;
		res_write  = wr_take & in_map & ((idx == `ARF_IDX_RES_LO) | (idx == `ARF_IDX_RES_HI));
	end

	property p_left_low;
		done_left |=> st_ff.result_low_byte[7:6] == $past(conv_data[1:0]);
	endproperty
	a_left_low: assert property (p_left_low) else $error("left low bits misplaced");

	property p_right_high;
		done_right |=> st_ff.result_high_byte[1:0] == $past(conv_data[9:8]);
	endproperty
	a_right_high: assert property (p_right_high) else $error("right high bits misplaced");

	property p_right_low;
		done_right |=> st_ff.result_low_byte == $past(conv_data[7:0]);
	endproperty
	a_right_low: assert property (p_right_low) else $error("right low byte wrong");

	property p_hold;
		!done_take && !res_write && rst_n |=> $stable(st_ff.result_low_byte) && $stable(st_ff.result_high_byte);
	endproperty
	a_hold: assert property (p_hold) else $error("result byte changed without cause");

	property p_right_zero;
		done_right |=> st_ff.result_high_byte[7:2] == 6'h00;
	endproperty
	a_right_zero: assert property (p_right_zero) else $error("right format upper bits not zero");

	property p_left_zero;
		done_left |=> st_ff.result_low_byte[5:0] == 6'h00;
	endproperty
	a_left_zero: assert property (p_left_zero) else $error("left format lower bits not zero");

	property p_left_high;
		done_left |=> st_ff.result_high_byte == $past(conv_data[9:2]);
	endproperty
	a_left_high: assert property (p_left_high) else $error("left high byte wrong");

	property p_busy_clear;
		done_take && !sw_start |=> !st_ff.conv_busy && !conv_start;
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("status bit not cleared on completion");

	// A one-edge reset also drops the status bit; that edge is not a completion
	property p_same_edge;
		$fell(st_ff.conv_busy) && !$past(wr_take) && $past(rst_n) |-> st_ff.result_low_byte == $past(fmt_lo) &&
			st_ff.result_high_byte == $past(fmt_hi);
	endproperty
	a_same_edge: assert property (p_same_edge) else $error("result not stored with status clear");

	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held for two cycles");

endmodule : arf_top

/* File: tb/arf_tb_top.sv */
// Self-checking bench for the result formatter: register bus, control outputs, conversions.
// Assumes the design files and arf_defines.svh are compiled first; bench drives every port.
`timescale 1ns/1ps
`include "arf_defines.svh"

module arf_tb_top;
	localparam int ACQ_CYC = 8;    // Acquisition wait, plain value
	logic        sys_clk;          // Bench clock
	logic        rst_n;            // Synchronous reset, low
	logic        cyc, stb, we;     // Bus request
	logic [7:0]  adr;              // Byte address
	logic [3:0]  sel;              // Byte lanes
	logic [31:0] wdat, rdat;       // Bus data
	logic        ack;              // Bus answer
	logic        done, start, pwr; // Conversion link
	logic        nref;             // Negative reference
	logic [9:0]  cdat;             // Engine result
	logic [4:0]  chan;             // Channel select
	logic [2:0]  clks;             // Clock choice
	logic [1:0]  pref;             // Positive reference
	logic [3:0]  trig;             // Trigger source
	logic [7:0]  exp_q[$];         // Expected read bytes, oldest first
	logic [7:0]  hi, lo, r;        // Expected bytes, random byte
	logic [9:0]  vals[3];          // Result values per format
	int          n_mismatch;       // Mismatches seen
	int          samples_checked;  // Comparisons made

	arf_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.conv_done(done), .conv_data(cdat), .conv_start(start), .conv_power(pwr),
		.conv_channel(chan), .conv_clk_sel(clks), .conv_nref(nref), .conv_pref(pref),
		.conv_trig_sel(trig));

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	// Ends the run with counts and verdict
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	// One comparison, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		samples_checked++;
		if (got !== want) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask : chk

	// Read answers matched against the oldest note; negedge avoids the ack edge race
	always @(negedge sys_clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (exp_q.size() == 0)
				chk(rdat, 32'hFFFF_FFFF);
			else
				chk(rdat, {24'h0, exp_q.pop_front()});
		end
	end

	// Classic single cycle; a read notes its expected byte in v
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
		int i;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, v};
		sel <= s;
		if (!w)
			exp_q.push_back(v);
		for (i = 0; i < 20 && ack !== 1'b1; i++)
			@(posedge sys_clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			n_mismatch++;
			print_verdict();
		end
	endtask : bus

	// Select channel, wait acquisition, start, complete, read back
	task automatic convert(input logic j, input logic [9:0] v);
		bus(1'b1, `ARF_OFF_CTRL1, {j, 7'h00}, 4'h1);
		bus(1'b1, `ARF_OFF_CTRL0, 8'h05, 4'h1);
		repeat (ACQ_CYC) @(posedge sys_clk);
		bus(1'b1, `ARF_OFF_CTRL0, 8'h07, 4'h1);
		chk({31'h0, start}, 32'h1);
		repeat (3) @(posedge sys_clk);
		done <= 1'b1;
		cdat <= v;
		@(posedge sys_clk);
		done <= 1'b0;
		cdat <= ~v;
		@(negedge sys_clk);
		chk({31'h0, start}, 32'h0);
		hi = j ? {6'h00, v[9:8]} : v[9:2];
		lo = j ? v[7:0] : {v[1:0], 6'h00};
		bus(1'b0, `ARF_OFF_RES_HI, hi, 4'h1);
		bus(1'b0, `ARF_OFF_RES_LO, lo, 4'h1);
		bus(1'b0, `ARF_OFF_CTRL0, 8'h05, 4'h1);
	endtask : convert

	// Main sequence
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		{cyc, stb, we, done} = 4'h0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		cdat = 10'h000;
		n_mismatch = 0;
		samples_checked = 0;
		void'($urandom(32'h329687a2));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		// Control reset values
		bus(1'b0, `ARF_OFF_CTRL0, 8'h00, 4'h1);
		bus(1'b0, `ARF_OFF_CTRL1, 8'h00, 4'h1);
		bus(1'b0, `ARF_OFF_TRIG, 8'h00, 4'h1);
		chk({15'h0, start, pwr, chan, clks, nref, pref, trig}, 32'h0);
		// All ones except the CTRL0 status bit; unimplemented bits read zero
		bus(1'b1, `ARF_OFF_CTRL0, 8'hFD, 4'h1);
		bus(1'b1, `ARF_OFF_CTRL1, 8'hFF, 4'h1);
		bus(1'b1, `ARF_OFF_TRIG, 8'hFF, 4'h1);
		bus(1'b0, `ARF_OFF_CTRL0, 8'h7D, 4'h1);
		bus(1'b0, `ARF_OFF_CTRL1, 8'hF7, 4'h1);
		bus(1'b0, `ARF_OFF_TRIG, 8'hF0, 4'h1);
		chk({16'h0, pwr, chan, clks, nref, pref, trig}, 32'h0000_FFFF);
		// Random control values; a write without lane 0 has no effect
		repeat (4) begin
			r = 8'($urandom);
			bus(1'b1, `ARF_OFF_CTRL1, r, 4'h1);
			bus(1'b1, `ARF_OFF_CTRL1, ~r, 4'h0);
			bus(1'b1, `ARF_OFF_TRIG, r, 4'h1);
			bus(1'b0, `ARF_OFF_CTRL1, r & 8'hF7, 4'h1);
			bus(1'b0, `ARF_OFF_TRIG, r & 8'hF0, 4'h1);
			chk({22'h0, clks, nref, pref, trig}, {22'h0, r[6:4], r[2:0], r[7:4]});
		end
		// Both formats, random and boundary results
		vals[0] = 10'($urandom);
		vals[1] = 10'h3FF;
		vals[2] = 10'h000;
		for (int j = 0; j < 2; j++)
			foreach (vals[k])
				convert(j[0], vals[k]);
		// Start then abort; a later completion is ignored
		bus(1'b1, `ARF_OFF_CTRL0, 8'h07, 4'h1);
		bus(1'b1, `ARF_OFF_CTRL0, 8'h05, 4'h1);
		bus(1'b0, `ARF_OFF_CTRL0, 8'h05, 4'h1);
		@(posedge sys_clk);
		done <= 1'b1;
		cdat <= 10'h155;
		@(posedge sys_clk);
		done <= 1'b0;
		bus(1'b0, `ARF_OFF_RES_HI, hi, 4'h1);
		bus(1'b0, `ARF_OFF_RES_LO, lo, 4'h1);
		// Result bytes writable and kept over reset
		bus(1'b1, `ARF_OFF_RES_LO, 8'hA5, 4'h1);
		bus(1'b1, `ARF_OFF_RES_HI, 8'h5A, 4'h1);
		bus(1'b1, `ARF_OFF_CTRL1, 8'h80, 4'h1);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(1'b0, `ARF_OFF_RES_LO, 8'hA5, 4'h1);
		bus(1'b0, `ARF_OFF_RES_HI, 8'h5A, 4'h1);
		bus(1'b0, `ARF_OFF_CTRL1, 8'h00, 4'h1);
		// Unmapped and misaligned places read zero
		bus(1'b1, 8'h14, 8'hFF, 4'h1);
		bus(1'b0, 8'h14, 8'h00, 4'h1);
		bus(1'b0, 8'h0D, 8'h00, 4'h1);
		bus(1'b0, 8'h41, 8'h00, 4'h1);
		print_verdict();
	end
endmodule : arf_tb_top
